// ---- src/cbs_pkg.sv ----
// Package for the channel data buffer steering block.
// Assumes a single 50 MHz processor bus clock and no software registers.
package cbs_pkg;

  // Reset-time strap meaning of the swap-direction pin
  localparam logic STRAP_COPROC_PRESENT = 1'b0;

  // Reset values of the buffer and steering controls (active low except swap direction, all idle high)
  localparam logic CTL_INACTIVE = 1'b1;
  localparam logic SWAP_DIR_RESET = 1'b1;

  // Cycle kinds requested by the channel controller
  typedef enum logic [2:0] {
    CBS_CYC_NONE = 3'b000,
    CBS_CYC_CPU_RD = 3'b001,
    CBS_CYC_CPU_WR = 3'b010,
    CBS_CYC_MST_RD = 3'b011,
    CBS_CYC_MST_WR = 3'b100
  } cbs_cyc_t;

  // Sequencer states
  typedef enum logic [2:0] {
    CBS_ST_IDLE = 3'b000,
    CBS_ST_FULL = 3'b001,
    CBS_ST_HALF1 = 3'b010,
    CBS_ST_HALF2 = 3'b011,
    CBS_ST_HOLD = 3'b100
  } cbs_state_t;

  // One request from the channel controller
  typedef struct packed {
    cbs_cyc_t kind;
    logic narrow_port;
    logic to_dram;
  } cbs_req_t;

  // Buffer control outputs, all active low except swap_direction
  typedef struct packed {
    logic swap_direction;
    logic byte_lane_steer_n;
    logic word_lane_steer_n;
    logic write_data_latch_en_n;
    logic upper_word_write_buf_en_n;
    logic byte1_write_buf_en_n;
    logic byte0_write_buf_en_n;
    logic low_byte_read_latch_en_n;
    logic read_buf_en_n;
  } cbs_ctl_t;

  // Whole state of the block
  typedef struct packed {
    cbs_state_t st;
    cbs_req_t req;
    cbs_ctl_t ctl;
    logic coproc_present;
    logic strap_taken;
  } cbs_regs_t;

  localparam cbs_ctl_t CTL_IDLE = '{
    swap_direction: SWAP_DIR_RESET,
    byte_lane_steer_n: CTL_INACTIVE,
    word_lane_steer_n: CTL_INACTIVE,
    write_data_latch_en_n: CTL_INACTIVE,
    upper_word_write_buf_en_n: CTL_INACTIVE,
    byte1_write_buf_en_n: CTL_INACTIVE,
    byte0_write_buf_en_n: CTL_INACTIVE,
    low_byte_read_latch_en_n: CTL_INACTIVE,
    read_buf_en_n: CTL_INACTIVE
  };

endpackage : cbs_pkg

// ---- src/cbs_steer.sv ----
// Channel data buffer steering: drives direction, swap, latch and lane enables.
// Assumes the channel controller presents one cycle request per start pulse and
// advances halves with phase_i; all inputs are synchronous to clk_i.
// How it works
// - Sample swap-direction pin at reset release
// - Low sample means coprocessor present
// - Swap direction low for read/master write
// - Swap direction high for write/master read
// - Narrow port access: two halves, byte steer
// - Narrow master to wide slave: word steer
// - Pulse write latch on CPU write only
// - Write latch holds data across both halves
// - Three separate write buffer lane enables
// - Write enables only CPU write/master DRAM read
// - Latch low byte first half, then present
// - Read enable on CPU read/master DRAM write
// - Test low floats swap pin and buffer controls
// - After reset data floats, controls inactive
`timescale 1ns/1ps
`default_nettype none
module cbs_steer
  import cbs_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Test pin, active low
  input wire logic test_n_i,
  // Cycle request from channel controller
  input wire logic start_i,
  input wire cbs_req_t req_i,
  input wire logic phase_i,
  input wire logic done_i,
  input wire logic narrow_master_translate_i,
  // Swap-direction pin, two-way
  input wire logic swap_direction_i,
  output logic swap_direction_o,
  output logic swap_direction_oe_o,
  // Buffer controls and their shared enable
  output cbs_ctl_t ctl_o,
  output logic ctl_oe_o,
  // Status
  output logic coproc_present_o,
  output logic busy_o
);

  // Reset synchroniser
  logic rst_q1_r;
  logic rst_q2_r;

  // Block state and its next value
  cbs_regs_t s_r;
  cbs_regs_t s_nxt;

  // Release the reset through two flops so the release is clean
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_q1_r <= 1'b0;
      rst_q2_r <= 1'b0;
    end else begin
      rst_q1_r <= 1'b1;
      rst_q2_r <= rst_q1_r;
    end
  end

  // Next-state logic
  always_comb begin
    s_nxt = s_r;
    // Strap taken on the first clock after release, pin still undriven
    if (!s_r.strap_taken) begin
      s_nxt.strap_taken = 1'b1;
      s_nxt.coproc_present = (swap_direction_i == STRAP_COPROC_PRESENT);
    end
    case (s_r.st)
      CBS_ST_IDLE: begin
        s_nxt.ctl = CTL_IDLE;
        if (start_i && s_r.strap_taken && req_i.kind != CBS_CYC_NONE) begin
          s_nxt.req = req_i;
          s_nxt.ctl = CTL_IDLE;
          // Direction: writes and master reads swap downward
          s_nxt.ctl.swap_direction = (req_i.kind == CBS_CYC_CPU_WR) ||
                                     (req_i.kind == CBS_CYC_MST_RD);
          case (req_i.kind)
            CBS_CYC_CPU_RD: begin
              s_nxt.ctl.read_buf_en_n = 1'b0;
              s_nxt.ctl.byte_lane_steer_n = !req_i.narrow_port;
              s_nxt.ctl.low_byte_read_latch_en_n = !req_i.narrow_port;
            end
            CBS_CYC_CPU_WR: begin
              // Latch write data so the channel sees its hold time
              s_nxt.ctl.write_data_latch_en_n = 1'b0;
              s_nxt.ctl.byte0_write_buf_en_n = 1'b0;
              s_nxt.ctl.byte1_write_buf_en_n = 1'b0;
              s_nxt.ctl.upper_word_write_buf_en_n = req_i.narrow_port;
              s_nxt.ctl.byte_lane_steer_n = !req_i.narrow_port;
            end
            CBS_CYC_MST_RD: begin
              // Master reads of board DRAM drive the channel lanes
              s_nxt.ctl.byte0_write_buf_en_n = !req_i.to_dram;
              s_nxt.ctl.byte1_write_buf_en_n = !req_i.to_dram;
              s_nxt.ctl.upper_word_write_buf_en_n = !req_i.to_dram;
              s_nxt.ctl.word_lane_steer_n = !narrow_master_translate_i;
            end
            CBS_CYC_MST_WR: begin
              s_nxt.ctl.read_buf_en_n = !req_i.to_dram;
              s_nxt.ctl.word_lane_steer_n = !narrow_master_translate_i;
            end
            default: begin
              s_nxt.ctl = CTL_IDLE;
            end
          endcase
          // Split cycles run two halves, others one
          if ((req_i.narrow_port && (req_i.kind == CBS_CYC_CPU_RD ||
               req_i.kind == CBS_CYC_CPU_WR)) ||
              (narrow_master_translate_i && (req_i.kind == CBS_CYC_MST_RD ||
               req_i.kind == CBS_CYC_MST_WR))) begin
            s_nxt.st = CBS_ST_HALF1;
          end else begin
            s_nxt.st = CBS_ST_FULL;
          end
        end
      end
      CBS_ST_HALF1: begin
        // Write latch enable is a single pulse; data stays latched after
        s_nxt.ctl.write_data_latch_en_n = CTL_INACTIVE;
        if (phase_i) begin
          s_nxt.st = CBS_ST_HALF2;
          // Low byte now held; second half reads the high byte
          s_nxt.ctl.low_byte_read_latch_en_n = CTL_INACTIVE;
        end
      end
      CBS_ST_FULL, CBS_ST_HALF2: begin
        s_nxt.ctl.write_data_latch_en_n = CTL_INACTIVE;
        if (done_i) begin
          s_nxt.st = CBS_ST_HOLD;
          // Close read path at once; write path stays one more cycle for hold
          s_nxt.ctl.read_buf_en_n = CTL_INACTIVE;
          s_nxt.ctl.low_byte_read_latch_en_n = CTL_INACTIVE;
        end
      end
      CBS_ST_HOLD: begin
        s_nxt.st = CBS_ST_IDLE;
        s_nxt.ctl = CTL_IDLE;
      end
      default: begin
        s_nxt.st = CBS_ST_IDLE;
        s_nxt.ctl = CTL_IDLE;
      end
    endcase
    // Safety: a read enable cancels all write enables on the same lanes
    if (!s_nxt.ctl.read_buf_en_n) begin
      s_nxt.ctl.byte0_write_buf_en_n = CTL_INACTIVE;
      s_nxt.ctl.byte1_write_buf_en_n = CTL_INACTIVE;
      s_nxt.ctl.upper_word_write_buf_en_n = CTL_INACTIVE;
    end
  end

  // State register; controls come straight from here so they cannot glitch
  always_ff @(posedge clk_i or negedge rst_q2_r) begin
    if (!rst_q2_r) begin
      s_r.st <= CBS_ST_IDLE;
      s_r.req <= '{kind: CBS_CYC_NONE, narrow_port: 1'b0, to_dram: 1'b0};
      s_r.ctl <= CTL_IDLE;
      s_r.coproc_present <= 1'b0;
      s_r.strap_taken <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Pin drivers; test low floats the swap pin and controls, status stays driven
  assign swap_direction_o = s_r.ctl.swap_direction;
  assign swap_direction_oe_o = test_n_i && s_r.strap_taken;
  assign ctl_o = s_r.ctl;
  assign ctl_oe_o = test_n_i;
  assign coproc_present_o = s_r.coproc_present;
  assign busy_o = (s_r.st != CBS_ST_IDLE);

endmodule : cbs_steer
`default_nettype wire

// ---- verif/cbs_far_end.sv ----
// Far side: strap resistor on the swap pin and the address buffer's translate.
// Assumes the bench says when a narrow master owns the channel.
`timescale 1ns/1ps
`default_nettype none
module cbs_far_end (
  // Swap pin parties
  input wire logic strap_lvl_i,
  input wire logic pin_o_i,
  input wire logic pin_oe_i,
  // Channel ownership
  input wire logic narrow_master_i,
  // Resolved pin and translate
  output logic pin_level_o,
  output logic translate_o
);
  // Released pin falls back to the strap resistor, never a stale value
  assign pin_level_o = pin_oe_i ? pin_o_i : strap_lvl_i;
  // Asserted only while a narrow master owns the channel
  assign translate_o = narrow_master_i;
endmodule : cbs_far_end
`default_nettype wire

// ---- verif/cbs_steer_props.sv ----
// Checker for the steering block, bound to its top module.
// Assumes one clock domain and sees only top ports.
`timescale 1ns/1ps
`default_nettype none
module cbs_steer_props
  import cbs_pkg::*;
(
  // Clock, reset, test
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic test_n_i,
  // Requests
  input wire logic start_i,
  input wire cbs_req_t req_i,
  // Outputs watched
  input wire logic swap_direction_oe_o,
  input wire cbs_ctl_t ctl_o,
  input wire logic ctl_oe_o,
  input wire logic coproc_present_o,
  input wire logic busy_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  chk_test_float: assert property (!test_n_i |-> !ctl_oe_o && !swap_direction_oe_o)
    else $error("outputs driven in test");
  chk_rw_excl: assert property (!(!ctl_o.read_buf_en_n && ctl_o[4:2] != 3'b111))
    else $error("read and write enables together");
  chk_latch_pulse: assert property ($fell(ctl_o.write_data_latch_en_n) |=> ctl_o.write_data_latch_en_n)
    else $error("write latch pulse not one cycle");
  chk_wr_dir: assert property (ctl_o[4:2] != 3'b111 |-> ctl_o.swap_direction)
    else $error("write lanes with wrong direction");
  chk_rd_dir: assert property (!ctl_o.read_buf_en_n |-> !ctl_o.swap_direction)
    else $error("read enable with wrong direction");
  chk_rd_latch: assert property (!ctl_o.low_byte_read_latch_en_n |-> !ctl_o.read_buf_en_n && !ctl_o.byte_lane_steer_n)
    else $error("read latch outside narrow read");
  chk_start_resp: assert property (start_i && swap_direction_oe_o && !busy_o && req_i.kind != CBS_CYC_NONE |=> busy_o)
    else $error("start not taken");
  chk_idle_ctl: assert property (!busy_o |-> ctl_o == CTL_IDLE)
    else $error("controls active while idle");
  chk_coproc_hold: assert property (swap_direction_oe_o && $past(swap_direction_oe_o) |-> $stable(coproc_present_o))
    else $error("coprocessor flag changed");
  cov_wr_latch: cover property ($fell(ctl_o.write_data_latch_en_n));
  cov_rd_latch: cover property ($fell(ctl_o.low_byte_read_latch_en_n));
  cov_word: cover property ($fell(ctl_o.word_lane_steer_n));
endmodule : cbs_steer_props
bind cbs_steer cbs_steer_props i_cbs_steer_props (.clk_i(clk_i), .nrst_i(nrst_i), .test_n_i(test_n_i),
  .start_i(start_i), .req_i(req_i), .swap_direction_oe_o(swap_direction_oe_o), .ctl_o(ctl_o),
  .ctl_oe_o(ctl_oe_o), .coproc_present_o(coproc_present_o), .busy_o(busy_o));
`default_nettype wire

// ---- verif/channel_data_buffer_steering_tb_top.sv ----
// Testbench for the steering block: walks each cycle kind and the test pin.
// Assumes the far-end model resolves the swap pin and translate.
`timescale 1ns/1ps
`default_nettype none
module channel_data_buffer_steering_tb_top;
  import cbs_pkg::*;
  logic clk_i = 1'b0, nrst_i = 1'b0, test_n_i = 1'b1, start_i = 1'b0, phase_i = 1'b0;
  logic done_i = 1'b0, strap = 1'b1, mst = 1'b0, tr, pin, sw_o, sw_oe, ctl_oe, cop, busy;
  cbs_req_t req_i = '0;
  cbs_ctl_t ctl;
  int n_errors = 0, cmp_count = 0;
  // Free-running 50 MHz clock
  always #10 clk_i = ~clk_i;
  cbs_far_end i_cbs_far_end (.strap_lvl_i(strap), .pin_o_i(sw_o), .pin_oe_i(sw_oe),
    .narrow_master_i(mst), .pin_level_o(pin), .translate_o(tr));
  cbs_steer i_cbs_steer (.clk_i(clk_i), .nrst_i(nrst_i), .test_n_i(test_n_i), .start_i(start_i),
    .req_i(req_i), .phase_i(phase_i), .done_i(done_i), .narrow_master_translate_i(tr),
    .swap_direction_i(pin), .swap_direction_o(sw_o), .swap_direction_oe_o(sw_oe), .ctl_o(ctl),
    .ctl_oe_o(ctl_oe), .coproc_present_o(cop), .busy_o(busy));
  // Compare nine bits with case equality so unknowns fail
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  // Reset with a given strap level; start is legal four edges after release
  task automatic do_reset(input logic s, input logic exp_cop);
    strap = s;
    nrst_i = 1'b0;
    repeat (6) @(negedge clk_i);
    nrst_i = 1'b1;
    repeat (4) @(negedge clk_i);
    chk({7'h00, cop, sw_oe}, {7'h00, exp_cop, 1'b1});
    chk(ctl, CTL_IDLE);
    $display("test reset strap %0d done", s);
  endtask : do_reset
  // One whole cycle; checks controls one cycle after start, then idle return
  task automatic run(input cbs_req_t r, input logic m, split, input logic [8:0] mask, exp);
    int k;
    mst = m;
    req_i = r;
    start_i = 1'b1;
    @(negedge clk_i);
    start_i = 1'b0;
    chk(ctl & mask, exp);
    chk({8'h00, busy}, 9'h001);
    if (split) begin
      @(negedge clk_i);
      phase_i = 1'b1;
      @(negedge clk_i);
      phase_i = 1'b0;
    end
    done_i = 1'b1;
    @(negedge clk_i);
    done_i = 1'b0;
    for (k = 0; k < 4 && busy !== 1'b0; k++) @(negedge clk_i);
    if (busy !== 1'b0) begin
      n_errors++;
      final_report();
    end
    chk(ctl, CTL_IDLE);
    mst = 1'b0;
  endtask : run
  task automatic t_narrow_cpu;
    run('{CBS_CYC_CPU_WR, 1'b1, 1'b0}, 1'b0, 1'b1, 9'h1ff, 9'h153);
    run('{CBS_CYC_CPU_RD, 1'b1, 1'b0}, 1'b0, 1'b1, 9'h1ff, 9'h07c);
    $display("test narrow cpu done");
  endtask : t_narrow_cpu
  task automatic t_master;
    run('{CBS_CYC_MST_RD, 1'b0, 1'b1}, 1'b1, 1'b1, 9'h1ff, 9'h1a3);
    run('{CBS_CYC_MST_WR, 1'b0, 1'b1}, 1'b1, 1'b1, 9'h1ff, 9'h0be);
    run('{CBS_CYC_MST_RD, 1'b0, 1'b0}, 1'b0, 1'b0, 9'h1ff, 9'h1ff);
    $display("test master done");
  endtask : t_master
  task automatic t_test_pin;
    test_n_i = 1'b0;
    @(negedge clk_i);
    chk({7'h00, ctl_oe, sw_oe}, 9'h000);
    test_n_i = 1'b1;
    @(negedge clk_i);
    chk({7'h00, ctl_oe, sw_oe}, 9'h003);
    $display("test pin done");
  endtask : t_test_pin
  initial begin
    do_reset(1'b1, 1'b0);
    do_reset(1'b0, 1'b1);
    t_narrow_cpu();
    t_master();
    t_test_pin();
    final_report();
  end
endmodule : channel_data_buffer_steering_tb_top
`default_nettype wire
